// *** shared/fbf_pkg.sv ***
package fbf_pkg;

  // Telegram header: two control bytes in, two status bytes out.
  localparam int unsigned HDR_BYTES = 2;

  // Control byte 0 and byte 1 bit positions, as the master encodes them.
  localparam int unsigned C0_CMD_MODE  = 0;
  localparam int unsigned C0_BROADCAST = 1;
  localparam int unsigned C0_ADDR_LSB  = 2;
  localparam int unsigned C0_FRESH     = 7;
  localparam int unsigned C1_READ_DONE = 0;
  localparam int unsigned C1_SEND_CMD  = 2;
  localparam int unsigned C1_LOAD_CMD  = 3;

  // Service selector codes.
  localparam logic [1:0] SVC_RUN = 2'h0;

  // Receive ring toward the master: 1 kByte, one frame-end tag per byte.
  localparam int unsigned RING_AW    = 10;
  localparam logic [10:0] RING_DEPTH = 11'h400;
  localparam int unsigned PL_AW      = 8;

  // Pending framing characters behind a payload.
  localparam logic [1:0] END_NONE = 2'h0;
  localparam logic [1:0] END_TWO  = 2'h1;
  localparam logic [1:0] END_ONE  = 2'h2;

  typedef enum logic [1:0] {
    FBF_IDLE = 2'b00,
    FBF_LOAD = 2'b01,
    FBF_SEND = 2'b10
  } fbf_ost_t;

  // One byte of a stream with its end-of-unit marker.
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } fbf_byte_t;

  typedef struct packed {
    logic [1:0]         svc_s1;
    logic [1:0]         svc_s2;
    logic [1:0]         in_idx;
    logic               start_sent;
    logic [1:0]         end_pend;
    logic [7:0]         ctrl0;
    logic [7:0]         ctrl1;
    logic               rack_seen;
    logic               blk_unack;
    logic [7:0]         buf0;
    logic [7:0]         buf1;
    logic [1:0]         buf_cnt;
    logic [RING_AW-1:0] wr_ptr;
    logic [RING_AW-1:0] rd_ptr;
    logic [10:0]        ring_cnt;
    logic [10:0]        frames;
    fbf_ost_t           ost;
    logic [7:0]         ld_cnt;
    logic [7:0]         len_code;
    logic [7:0]         snap0;
    logic [8:0]         pos;
    fbf_byte_t          mtx;
    logic               mtx_valid;
    logic               write_done;
    logic               block_ready;
    logic               fresh_data;
    logic               data_lost;
    logic               buffer_full;
  } fbf_state_t;

  localparam fbf_state_t STATE_RST = '0;

endpackage

// *** hw/fbf_framer.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Telegrams start with two control or status bytes; payload starts at byte three.
// - Payload toward the master beyond configured length is discarded and data-lost is raised.
// - Control bytes are consumed; only payload goes to serial, wrapped in framing characters.
// - Status byte 0 carries write-done, service, pending, block-ready, lost, full, fresh bits.
// - Status byte 1 holds the count of valid payload bytes that follow.
// - Toggles invert once per event; receivers compare against the previous value.
// - Write-done toggles on each completed buffer-load or buffer-send command.
// - Service-active is set while the selector is in any of its three service positions.
// - Pending-data is high while the buffer toward the master holds data.
// - Fresh-data toggle is maintained only in transparent operation.
// - Block-ready toggles once each time a received frame, up to its frame end, has been moved into the payload bytes.
// - Data-lost stays set until the reset command clears it.
// - Buffer-full sets on overflow, clears when space frees, and drops request-to-send.
// - Fresh-data toggles for every data set loaded for the master in transparent operation.
module fbf_framer
  import fbf_pkg::*;
(
  // Clock and reset.
  input  wire logic      REF_CLK,
  input  wire logic      NRST,
  // Telegram bytes from the master.
  input  wire fbf_byte_t M_RX_BEAT,
  input  wire logic      M_RX_VALID,
  output logic           M_RX_READY,
  // Telegram bytes toward the master.
  input  wire logic      M_TX_REQ,
  output fbf_byte_t      M_TX_BEAT,
  output logic           M_TX_VALID,
  input  wire logic      M_TX_READY,
  // Deframed bytes from the end device; last marks the frame end.
  input  wire fbf_byte_t S_RX_BEAT,
  input  wire logic      S_RX_VALID,
  output logic           S_RTS,
  // Framed bytes toward the end device.
  output logic [7:0]     S_TX_DATA,
  output logic           S_TX_VALID,
  input  wire logic      S_TX_READY,
  // Configuration.
  input  wire logic [7:0] CFG_PAYLOAD_LEN,
  input  wire logic      CFG_COLLECTIVE,
  input  wire logic [7:0] CFG_START_CHAR,
  input  wire logic [7:0] CFG_END_CHAR1,
  input  wire logic [7:0] CFG_END_CHAR2,
  input  wire logic      CFG_END2_EN,
  // Service selector pin and reset command.
  input  wire logic [1:0] SERVICE_SEL,
  input  wire logic      CLR_DATA_LOST,
  // Status bytes as currently maintained.
  output logic [7:0]     STATUS0,
  output logic [7:0]     STATUS1
);

  fbf_state_t q;
  fbf_state_t n;

  // Memories are kept outside the state record; they need no reset.
  logic [8:0] ring_mem [0:(1<<RING_AW)-1];
  logic [7:0] pl_mem   [0:(1<<PL_AW)-1];

  logic       ring_we;
  logic       pl_we;
  logic       buf_ready;
  logic       push_req;
  logic [7:0] push_data;
  logic       push_acc;
  logic       pop;
  logic [1:0] c;
  logic [8:0] ring_rd;
  logic       svc_active;

  // Status byte 0 layout, with bit 1 unused.
  function automatic logic [7:0] status0_of(fbf_state_t s, logic svc);
    return {s.fresh_data, s.buffer_full, s.data_lost, s.block_ready,
            (s.ring_cnt != 11'h000), svc, 1'b0, s.write_done};
  endfunction

  // Both load and send commands complete with the telegram that carries them.
  function automatic logic is_cmd(logic [7:0] c1);
    return c1[C1_LOAD_CMD] | c1[C1_SEND_CMD];
  endfunction

  assign ring_rd    = ring_mem[q.rd_ptr];
  assign svc_active = (q.svc_s2 != SVC_RUN);
  assign buf_ready  = (q.buf_cnt != 2'h2);

  // All state moves here; memory write strobes come out alongside.
  always_comb
  begin
    n          = q;
    ring_we    = 1'b0;
    pl_we      = 1'b0;
    push_req   = 1'b0;
    push_data  = 8'h00;
    M_RX_READY = 1'b0;
    c          = q.buf_cnt;
    pop        = S_TX_READY && (q.buf_cnt != 2'h0);

    // The selector is a pin; only the second stage is read.
    n.svc_s1 = SERVICE_SEL;
    n.svc_s2 = q.svc_s1;

    // The reset command clears first, so a loss later in this cycle still sets the flag.
    if (CLR_DATA_LOST)
    begin
      n.data_lost = 1'b0;
    end

    // Inbound telegram: header bytes are taken, payload is framed.
    if (q.end_pend != END_NONE)
    begin
      push_req  = 1'b1;
      push_data = (q.end_pend == END_ONE) ? CFG_END_CHAR1 : CFG_END_CHAR2;
    end
    else if (M_RX_VALID)
    begin
      if (q.in_idx < 2'(HDR_BYTES))
      begin
        M_RX_READY = 1'b1;
        if (q.in_idx == 2'h0)
        begin
          n.ctrl0 = M_RX_BEAT.data;
        end
        else
        begin
          n.ctrl1 = M_RX_BEAT.data;
          if (M_RX_BEAT.data[C1_READ_DONE] != q.rack_seen)
          begin
            n.rack_seen = M_RX_BEAT.data[C1_READ_DONE];
            n.blk_unack = 1'b0;
          end
        end
        if (M_RX_BEAT.last)
        begin
          n.in_idx = 2'h0;
          if (q.in_idx == 2'h1 && is_cmd(M_RX_BEAT.data))
          begin
            n.write_done = ~q.write_done;
          end
        end
        else
        begin
          n.in_idx = q.in_idx + 2'h1;
        end
      end
      else if (!q.start_sent)
      begin
        push_req  = 1'b1;
        push_data = CFG_START_CHAR;
      end
      else
      begin
        push_req   = 1'b1;
        push_data  = M_RX_BEAT.data;
        M_RX_READY = buf_ready;
      end
    end
    push_acc = push_req && buf_ready;

    // Bookkeeping once a framing or payload byte is taken.
    if (push_acc)
    begin
      if (q.end_pend == END_ONE)
      begin
        n.end_pend = CFG_END2_EN ? END_TWO : END_NONE;
      end
      else if (q.end_pend == END_TWO)
      begin
        n.end_pend = END_NONE;
      end
      else if (!q.start_sent)
      begin
        n.start_sent = 1'b1;
      end
      else if (M_RX_BEAT.last)
      begin
        n.end_pend   = END_ONE;
        n.in_idx     = 2'h0;
        n.start_sent = 1'b0;
        if (is_cmd(q.ctrl1))
        begin
          n.write_done = ~q.write_done;
        end
      end
    end

    // Two-entry buffer toward the end device: pop first, then push.
    if (pop)
    begin
      n.buf0 = q.buf1;
      c      = c - 2'h1;
    end
    if (push_acc)
    begin
      if (c == 2'h0)
      begin
        n.buf0 = push_data;
      end
      else
      begin
        n.buf1 = push_data;
      end
      c = c + 2'h1;
    end
    n.buf_cnt = c;

    // Receive ring from the end device; overflow drops the byte.
    if (S_RX_VALID)
    begin
      if (q.ring_cnt != RING_DEPTH)
      begin
        ring_we  = 1'b1;
        n.wr_ptr = q.wr_ptr + RING_AW'(1);
      end
      else
      begin
        n.buffer_full = 1'b1;
        n.data_lost   = 1'b1;
      end
    end

    // Outbound telegram engine; loading never overlaps sending.
    unique case (q.ost)
      FBF_IDLE:
      begin
        if (M_TX_REQ)
        begin
          n.snap0 = status0_of(q, svc_active);
          n.pos   = 9'h000;
          n.ost   = FBF_SEND;
        end
        else if (q.frames != 11'h000 && !(CFG_COLLECTIVE && q.blk_unack))
        begin
          n.ld_cnt = 8'h00;
          n.ost    = FBF_LOAD;
        end
      end
      FBF_LOAD:
      begin
        n.rd_ptr = q.rd_ptr + RING_AW'(1);
        if (q.ld_cnt < CFG_PAYLOAD_LEN)
        begin
          pl_we    = 1'b1;
          n.ld_cnt = q.ld_cnt + 8'h01;
        end
        else
        begin
          n.data_lost = 1'b1;
        end
        if (ring_rd[0])
        begin
          n.len_code    = pl_we ? q.ld_cnt + 8'h01 : q.ld_cnt;
          n.block_ready = ~q.block_ready;
          n.blk_unack   = 1'b1;
          if (!CFG_COLLECTIVE)
          begin
            n.fresh_data = ~q.fresh_data;
          end
          n.ost = FBF_IDLE;
        end
      end
      FBF_SEND:
      begin
        if (!q.mtx_valid || M_TX_READY)
        begin
          if (q.mtx_valid && q.mtx.last)
          begin
            n.mtx_valid = 1'b0;
            n.ost       = FBF_IDLE;
          end
          else
          begin
            n.mtx_valid = 1'b1;
            n.pos       = q.pos + 9'h001;
            n.mtx.last  = (q.pos == {1'b0, q.len_code} + 9'h001);
            if (q.pos == 9'h000)
            begin
              n.mtx.data = q.snap0;
            end
            else if (q.pos == 9'h001)
            begin
              n.mtx.data = q.len_code;
            end
            else
            begin
              n.mtx.data = pl_mem[8'(q.pos - 9'h002)];
            end
          end
        end
      end
      default:
      begin
        n.ost = FBF_IDLE;
      end
    endcase

    // Ring occupancy and complete-frame count follow both pointers.
    n.ring_cnt = q.ring_cnt + {10'h000, ring_we} - {10'h000, (q.ost == FBF_LOAD)};
    n.frames   = q.frames + {10'h000, ring_we && S_RX_BEAT.last}
               - {10'h000, (q.ost == FBF_LOAD) && ring_rd[0]};
    if (q.buffer_full && q.ring_cnt != RING_DEPTH && !(S_RX_VALID && !ring_we))
    begin
      n.buffer_full = 1'b0;
    end
  end

  // Memory writes.
  always_ff @(posedge REF_CLK)
  begin
    if (ring_we)
    begin
      ring_mem[q.wr_ptr] <= {S_RX_BEAT.data, S_RX_BEAT.last};
    end
    if (pl_we)
    begin
      pl_mem[q.ld_cnt] <= ring_rd[8:1];
    end
  end

  // State register.
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      q <= STATE_RST;
    end
    else
    begin
      q <= n;
    end
  end

  // Outputs; the end device is held off while the ring is overflowing.
  assign M_TX_BEAT  = q.mtx;
  assign M_TX_VALID = q.mtx_valid;
  assign S_TX_DATA  = q.buf0;
  assign S_TX_VALID = (q.buf_cnt != 2'h0);
  assign S_RTS      = ~q.buffer_full;
  assign STATUS0    = status0_of(q, svc_active);
  assign STATUS1    = q.len_code;

endmodule // fbf_framer

// *** test/fbf_framer_sva.sv ***
`timescale 1ns/1ps
module fbf_chk
  import fbf_pkg::*;
(
  // Clock and reset.
  input wire logic       REF_CLK,
  input wire logic       NRST,
  // Master side.
  input wire fbf_byte_t  M_RX_BEAT,
  input wire logic       M_RX_VALID,
  input wire logic       M_RX_READY,
  input wire fbf_byte_t  M_TX_BEAT,
  input wire logic       M_TX_VALID,
  input wire logic       M_TX_READY,
  // Serial side.
  input wire logic       S_RTS,
  input wire logic [7:0] S_TX_DATA,
  input wire logic       S_TX_VALID,
  input wire logic       S_TX_READY,
  // Configuration, selector and status.
  input wire logic [7:0] CFG_PAYLOAD_LEN,
  input wire logic       CFG_COLLECTIVE,
  input wire logic [1:0] SERVICE_SEL,
  input wire logic       CLR_DATA_LOST,
  input wire logic [7:0] STATUS0,
  input wire logic [7:0] STATUS1
);
  logic take_last;

  // The edge that takes a telegram's final byte is the only cause of a write-done toggle.
  assign take_last = M_RX_VALID && M_RX_READY && M_RX_BEAT.last;

  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  property p_rts; S_RTS != STATUS0[6]; endproperty
  a_rts: assert property (p_rts) else $error("rts vs full");
  property p_svc; $stable(SERVICE_SEL) [*3] |-> STATUS0[2] == (SERVICE_SEL != 2'h0); endproperty
  a_svc: assert property (p_svc) else $error("service flag");
  property p_lost; STATUS0[5] && !CLR_DATA_LOST |=> STATUS0[5]; endproperty
  a_lost: assert property (p_lost) else $error("lost dropped");
  property p_wdone; $changed(STATUS0[0]) |-> $past(take_last); endproperty
  a_wdone: assert property (p_wdone) else $error("stray write-done");
  property p_mhold; M_TX_VALID && !M_TX_READY |=> M_TX_VALID && $stable(M_TX_BEAT); endproperty
  a_mhold: assert property (p_mhold) else $error("master beat moved");
  property p_shold; S_TX_VALID && !S_TX_READY |=> S_TX_VALID && $stable(S_TX_DATA); endproperty
  a_shold: assert property (p_shold) else $error("serial byte moved");
  property p_len; STATUS1 <= CFG_PAYLOAD_LEN; endproperty
  a_len: assert property (p_len) else $error("length too big");
  property p_coll; CFG_COLLECTIVE |=> $stable(STATUS0[7]); endproperty
  a_coll: assert property (p_coll) else $error("fresh moved");

  // Main scenarios seen at least once.
  c_wd: cover property ($changed(STATUS0[0]));
  c_full: cover property (STATUS0[6]);
  c_svc: cover property (STATUS0[2]);
endmodule // fbf_chk

bind fbf_framer fbf_chk fbf_chk_inst (.*);

// *** test/fbf_master_model.sv ***
`timescale 1ns/1ps
module fbf_master_model
  import fbf_pkg::*;
(
  // Clock.
  input wire logic      REF_CLK,
  // Control telegrams toward the gateway.
  output fbf_byte_t     M_RX_BEAT,
  output logic          M_RX_VALID,
  input wire logic      M_RX_READY,
  // Status telegrams from the gateway.
  output logic          M_TX_REQ,
  input wire fbf_byte_t M_TX_BEAT,
  input wire logic      M_TX_VALID,
  output logic          M_TX_READY
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  logic       rack = 1'b0;

  // Idle master at time zero.
  initial
  begin
    M_RX_BEAT = '0;
    M_RX_VALID = 1'b0;
    M_TX_REQ = 1'b0;
    M_TX_READY = 1'b0;
  end

  // Two control bytes, then n payload bytes counting up from b; each held until taken.
  task automatic send(input logic [7:0] c0, input logic [7:0] c1, input int n, input logic [7:0] b);
    int k;
    for (int i = 0; i < n + 2; i++)
    begin
      M_RX_BEAT.data = (i == 0) ? c0 : (i == 1) ? c1 : b + 8'(i - 2);
      M_RX_BEAT.last = (i == n + 1);
      M_RX_VALID = 1'b1;
      k = 0;
      do
      begin
        @(posedge REF_CLK);
        k++;
      end
      while (!M_RX_READY && k < 40);
      if (!M_RX_READY)
        testbench.hang();
      #1;
    end
    M_RX_VALID = 1'b0;
    M_RX_BEAT = ~M_RX_BEAT;
  endtask

  // Acknowledges a block by flipping read-done, never by holding a level.
  task automatic ack();
    rack = ~rack;
    send(8'h00, {7'h0, rack}, 0, 8'h00);
  endtask

  // Requests one status telegram; in slow mode ready stalls every other cycle.
  task automatic poll();
    int k;
    got.delete();
    M_TX_REQ = 1'b1;
    @(posedge REF_CLK);
    #1;
    M_TX_REQ = 1'b0;
    for (k = 0; k < 600; k++)
    begin
      M_TX_READY = slow ? k[0] : 1'b1;
      @(posedge REF_CLK);
      if (M_TX_VALID && M_TX_READY)
        got.push_back(M_TX_BEAT.data);
      if (M_TX_VALID && M_TX_READY && M_TX_BEAT.last)
        break;
      #1;
    end
    #1;
    M_TX_READY = 1'b0;
    if (k == 600)
      testbench.hang();
  endtask
endmodule // fbf_master_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import fbf_pkg::*;
;
  logic       ref_clk;
  logic       nrst;
  fbf_byte_t  m_rx_beat;
  fbf_byte_t  m_tx_beat;
  fbf_byte_t  s_rx_beat;
  logic       m_rx_valid, m_rx_ready, m_tx_req, m_tx_valid, m_tx_ready;
  logic       s_rx_valid, s_rts, s_tx_valid, s_tx_ready, coll, clr_lost, end2;
  logic [7:0] s_tx_data, st0, st1;
  logic [1:0] svc;
  logic [7:0] sq[$];
  logic [7:0] exp[$];
  int         errors;
  int         comparisons;

  fbf_framer fbf_framer_inst (
    .REF_CLK(ref_clk), .NRST(nrst),
    .M_RX_BEAT(m_rx_beat), .M_RX_VALID(m_rx_valid), .M_RX_READY(m_rx_ready),
    .M_TX_REQ(m_tx_req), .M_TX_BEAT(m_tx_beat), .M_TX_VALID(m_tx_valid), .M_TX_READY(m_tx_ready),
    .S_RX_BEAT(s_rx_beat), .S_RX_VALID(s_rx_valid), .S_RTS(s_rts),
    .S_TX_DATA(s_tx_data), .S_TX_VALID(s_tx_valid), .S_TX_READY(s_tx_ready),
    .CFG_PAYLOAD_LEN(8'h04), .CFG_COLLECTIVE(coll), .CFG_START_CHAR(8'h02),
    .CFG_END_CHAR1(8'h0D), .CFG_END_CHAR2(8'h0A), .CFG_END2_EN(end2),
    .SERVICE_SEL(svc), .CLR_DATA_LOST(clr_lost), .STATUS0(st0), .STATUS1(st1)
  );

  fbf_master_model mst (
    .REF_CLK(ref_clk), .M_RX_BEAT(m_rx_beat), .M_RX_VALID(m_rx_valid), .M_RX_READY(m_rx_ready),
    .M_TX_REQ(m_tx_req), .M_TX_BEAT(m_tx_beat), .M_TX_VALID(m_tx_valid), .M_TX_READY(m_tx_ready)
  );

  // Clock of 50 ns.
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // The serial receiver stalls every other cycle so the two-entry buffer must hold.
  always @(posedge ref_clk) s_tx_ready <= #1 ~s_tx_ready;

  // Collects every byte the end device takes.
  always @(posedge ref_clk) if (s_tx_valid && s_tx_ready) sq.push_back(s_tx_data);

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic hang();
    errors++;
    final_report();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // End-device bytes counting up from b, one per cycle, a frame end every per bytes.
  task automatic sframe(input int n, input logic [7:0] b, input int per);
    for (int i = 0; i < n; i++)
    begin
      s_rx_beat.data = b + 8'(i);
      s_rx_beat.last = (i % per == per - 1);
      s_rx_valid = 1'b1;
      tick(1);
    end
    s_rx_valid = 1'b0;
    s_rx_beat = ~s_rx_beat;
  endtask

  // Load then send command; only the framed payload reaches the serial side.
  task automatic t_down();
    exp = '{8'h02, 8'h50, 8'h51, 8'h52, 8'h0D, 8'h0A};
    mst.send(8'hA5, 8'h08, 3, 8'h50);
    tick(20);
    check(8'(sq.size()), 8'h06);
    foreach (exp[i]) check(sq[i], exp[i]);
    check(st0, 8'h01);
    mst.send(8'hA5, 8'h04, 0, 8'h00);
    tick(6);
    check(st0, 8'h00);
    check(8'(sq.size()), 8'h06);
    // With the second end character switched off, one payload byte is closed by a single end character.
    end2 = 1'b0;
    mst.send(8'hA5, 8'h00, 1, 8'h60);
    tick(12);
    end2 = 1'b1;
    check(8'(sq.size()), 8'h09);
    check(sq[7], 8'h60);
    check(sq[8], 8'h0D);
  endtask

  // A six-byte frame is cut to four bytes; the status telegram says so.
  task automatic t_up();
    sframe(2, 8'h30, 99);
    check(st0 & 8'h08, 8'h08);
    tick(1);
    sframe(4, 8'h32, 4);
    tick(12);
    mst.slow = 1'b1;
    mst.poll();
    exp = '{8'hB0, 8'h04, 8'h30, 8'h31, 8'h32, 8'h33};
    check(8'(mst.got.size()), 8'h06);
    foreach (exp[i]) check(mst.got[i], exp[i]);
    clr_lost = 1'b1;
    tick(1);
    clr_lost = 1'b0;
    check(st0, 8'h90);
  endtask

  // Every service position raises the flag; normal operation clears it.
  task automatic t_svc();
    for (int c = 1; c < 4; c++)
    begin
      svc = 2'(c);
      tick(4);
      check(st0 & 8'h04, 8'h04);
      svc = 2'h0;
      tick(4);
      check(st0 & 8'h04, 8'h00);
    end
  endtask

  // Collective mode overfills the ring; one acknowledge frees a block.
  task automatic t_full();
    coll = 1'b1;
    tick(2);
    sframe(1040, 8'h00, 4);
    check(st0 & 8'h68, 8'h68);
    check({7'h0, s_rts}, 8'h00);
    mst.ack();
    tick(8);
    check(st0 & 8'h40, 8'h00);
    check({7'h0, s_rts}, 8'h01);
    mst.poll();
    check(mst.got[1], 8'h04);
  endtask

  // Reset, then the scenarios in turn.
  initial
  begin
    errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    s_rx_beat = '0;
    s_rx_valid = 1'b0;
    s_tx_ready = 1'b0;
    coll = 1'b0;
    clr_lost = 1'b0;
    end2 = 1'b1;
    svc = 2'h0;
    repeat (12) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    tick(1);
    check(st0, 8'h00);
    check(st1, 8'h00);
    check({7'h0, s_rts}, 8'h01);
    t_down();
    t_up();
    t_svc();
    t_full();
    final_report();
  end
endmodule // testbench
